/* File: rtl/lpcd_decoder.sv */
`timescale 1ns/1ps
module lpcd_decoder
	import lpcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	// command in
	input wire logic cmd_valid,
	input wire logic [9:0] command_field_code,
	input wire logic [15:0] cmd_handle,
	input wire logic [7:0] cmd_flags,
	input wire logic [7:0] cmd_service_type,
	input wire logic [31:0] cmd_token_rate,
	input wire logic [31:0] cmd_peak_bw,
	input wire logic [31:0] cmd_latency_us,
	input wire logic [31:0] cmd_delay_var_us,
	output logic cmd_ready,
	input wire logic [3:0] event_mask,
	// link table maintenance from connection logic
	input wire logic link_set,
	input wire logic [IDX_W-1:0] link_set_idx,
	input wire logic [HANDLE_W-1:0] link_set_handle,
	input wire logic link_set_active,
	input wire logic link_set_parked,
	input wire logic link_set_slave,
	// link manager request
	output logic lm_req,
	output logic [1:0] lm_op,
	output logic [HANDLE_W-1:0] lm_handle,
	output logic [7:0] lm_service_type,
	output logic [31:0] lm_token_rate,
	output logic [31:0] lm_peak_bw,
	output logic [31:0] lm_latency_us,
	output logic [31:0] lm_delay_var_us,
	// link manager answer
	input wire logic lm_done,
	input wire logic [7:0] lm_status,
	input wire logic [7:0] lm_service_type_g,
	input wire logic [31:0] lm_token_rate_g,
	input wire logic [31:0] lm_peak_bw_g,
	input wire logic [31:0] lm_latency_g,
	input wire logic [31:0] lm_delay_var_g,
	input wire logic lm_remote_qos,
	// event out
	output logic ev_valid,
	output logic [2:0] ev_code,
	output logic [9:0] ev_opcode,
	output logic [7:0] ev_status,
	output logic [HANDLE_W-1:0] ev_handle,
	output logic [7:0] ev_role,
	output logic [7:0] ev_service_type,
	output logic [31:0] ev_token_rate,
	output logic [31:0] ev_peak_bw,
	output logic [31:0] ev_latency_us,
	output logic [31:0] ev_delay_var_us
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LOOK = 3'b001,
		S_READ = 3'b010,
		S_CHECK = 3'b011,
		S_WAIT_LM = 3'b100
	} lpcd_st_t;

	// ==========================================================
	// state
	// ==========================================================
	lpcd_st_t st_q, st_d;
	logic [9:0] op_q, op_d;
	logic [HANDLE_W-1:0] hdl_q, hdl_d;
	logic hdl_rsv_q, hdl_rsv_d;
	logic [7:0] svc_q, svc_d;
	logic [31:0] tok_q, tok_d, pk_q, pk_d, lat_q, lat_d, dv_q, dv_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic lm_req_q, lm_req_d;
	logic [1:0] lm_op_q, lm_op_d;
	logic ev_valid_q, ev_valid_d;
	lpcd_ev_t ev_code_q, ev_code_d;
	logic [7:0] ev_st_q, ev_st_d, ev_role_q, ev_role_d, ev_svc_q, ev_svc_d;
	logic [31:0] ev_tok_q, ev_tok_d, ev_pk_q, ev_pk_d, ev_lat_q, ev_lat_d;
	logic [31:0] ev_dv_q, ev_dv_d;
	logic ready_q, ready_d;
	logic park_clr;

	logic map_hit, rd_active, rd_parked, rd_slave;
	logic [IDX_W-1:0] map_idx;

	lpcd_handle_map u_map (
		.mclk(mclk),
		.rst_b(rst_b),
		.set_en(link_set),
		.set_idx(link_set_idx),
		.set_handle(link_set_handle),
		.look_handle(hdl_q),
		.hit(map_hit),
		.hit_idx(map_idx)
	);

	lpcd_link_table u_tab (
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(link_set),
		.wr_idx(link_set_idx),
		.wr_active(link_set_active),
		.wr_parked(link_set_parked),
		.wr_slave(link_set_slave),
		.park_clr(park_clr),
		.park_idx(idx_q),
		.rd_idx(idx_d),
		.rd_active(rd_active),
		.rd_parked(rd_parked),
		.rd_slave(rd_slave)
	);

	// event gate: masked events simply do not appear
	function automatic logic ev_on(input lpcd_ev_t c, input logic [3:0] m);
		case (c)
			EV_CMD_STATUS: ev_on = m[EVM_STATUS];
			EV_CMD_COMPLETE: ev_on = m[EVM_COMPLETE];
			EV_MODE_CHANGE: ev_on = m[EVM_MODE];
			EV_QOS_DONE: ev_on = m[EVM_QOS];
			default: ev_on = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// next state
	// ==========================================================
	always_comb begin
		logic [7:0] err;
		logic link_ok;
		err = ST_SUCCESS;
		link_ok = 1'b0;
		st_d = st_q;
		op_d = op_q;
		hdl_d = hdl_q;
		hdl_rsv_d = hdl_rsv_q;
		svc_d = svc_q;
		tok_d = tok_q;
		pk_d = pk_q;
		lat_d = lat_q;
		dv_d = dv_q;
		idx_d = idx_q;
		lm_req_d = 1'b0;
		lm_op_d = lm_op_q;
		ev_valid_d = 1'b0;
		ev_code_d = ev_code_q;
		ev_st_d = ev_st_q;
		ev_role_d = ev_role_q;
		ev_svc_d = ev_svc_q;
		ev_tok_d = ev_tok_q;
		ev_pk_d = ev_pk_q;
		ev_lat_d = ev_lat_q;
		ev_dv_d = ev_dv_q;
		ready_d = ready_q;
		park_clr = 1'b0;
		case (st_q)
			S_IDLE: begin
				ready_d = 1'b1;
				if (cmd_valid && ready_q) begin
					ready_d = 1'b0;
					op_d = command_field_code;
					hdl_d = cmd_handle[HANDLE_W-1:0];
					hdl_rsv_d = (cmd_handle[HANDLE_W-1:0] > HANDLE_MAX);
					svc_d = cmd_service_type;
					tok_d = cmd_token_rate;
					pk_d = cmd_peak_bw;
					lat_d = cmd_latency_us;
					dv_d = cmd_delay_var_us;
					st_d = S_LOOK;
				end
			end
			S_LOOK: begin
				st_d = S_READ;
			end
			S_READ: begin
				idx_d = map_idx;
				st_d = S_CHECK;
			end
			S_CHECK: begin
				link_ok = map_hit && rd_active && !hdl_rsv_q;
				if (!link_ok) begin
					err = ST_NO_CONN;
				end
				if (op_q == CODE_LEAVE_PARK && link_ok && !rd_parked) begin
					err = ST_BAD_PARAM;
				end
				if (op_q == CODE_SVC_QUALITY && link_ok && svc_q > SVC_GUARANTEED) begin
					err = ST_BAD_PARAM;
				end
				if (op_q != CODE_LEAVE_PARK && op_q != CODE_SVC_QUALITY
					&& op_q != CODE_ROLE_QUERY) begin
					err = ST_UNKNOWN_CMD;
				end
				ev_st_d = err;
				ev_role_d = rd_slave ? ROLE_SLAVE : ROLE_MASTER;
				if (op_q == CODE_ROLE_QUERY) begin
					ev_code_d = EV_CMD_COMPLETE;
					ev_valid_d = ev_on(EV_CMD_COMPLETE, event_mask);
					st_d = S_IDLE;
				end else begin
					ev_code_d = EV_CMD_STATUS;
					ev_valid_d = ev_on(EV_CMD_STATUS, event_mask);
					if (err == ST_SUCCESS) begin
						lm_req_d = 1'b1;
						if (op_q == CODE_LEAVE_PARK) begin
							lm_op_d = LM_OP_UNPARK;
						end else if (rd_slave) begin
							lm_op_d = LM_OP_QOS_TO_MASTER;
						end else begin
							lm_op_d = LM_OP_QOS_TO_SLAVE;
						end
						st_d = S_WAIT_LM;
					end else begin
						st_d = S_IDLE;
					end
				end
			end
			S_WAIT_LM: begin
				if (lm_done) begin
					ev_st_d = lm_status;
					if (op_q == CODE_LEAVE_PARK) begin
						ev_code_d = EV_MODE_CHANGE;
						ev_valid_d = ev_on(EV_MODE_CHANGE, event_mask);
						park_clr = (lm_status == ST_SUCCESS);
					end else begin
						ev_code_d = EV_QOS_DONE;
						ev_valid_d = ev_on(EV_QOS_DONE, event_mask);
						ev_svc_d = lm_service_type_g;
						ev_tok_d = lm_token_rate_g;
						ev_pk_d = lm_peak_bw_g;
						ev_lat_d = lm_latency_g;
						ev_dv_d = lm_delay_var_g;
					end
					st_d = S_IDLE;
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
		// unsolicited done event from peer negotiation
		if (lm_remote_qos && st_q != S_WAIT_LM && !ev_valid_d) begin
			ev_code_d = EV_QOS_DONE;
			ev_valid_d = ev_on(EV_QOS_DONE, event_mask);
			ev_st_d = lm_status;
			ev_svc_d = lm_service_type_g;
			ev_tok_d = lm_token_rate_g;
			ev_pk_d = lm_peak_bw_g;
			ev_lat_d = lm_latency_g;
			ev_dv_d = lm_delay_var_g;
		end
	end

	// ==========================================================
	// registers
	// ==========================================================
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_q <= S_IDLE;
			op_q <= '0;
			hdl_q <= '0;
			hdl_rsv_q <= 1'b0;
			svc_q <= '0;
			tok_q <= '0;
			pk_q <= '0;
			lat_q <= '0;
			dv_q <= '0;
			idx_q <= '0;
			lm_req_q <= 1'b0;
			lm_op_q <= LM_OP_UNPARK;
			ev_valid_q <= 1'b0;
			ev_code_q <= EV_NONE;
			ev_st_q <= '0;
			ev_role_q <= '0;
			ev_svc_q <= '0;
			ev_tok_q <= '0;
			ev_pk_q <= '0;
			ev_lat_q <= '0;
			ev_dv_q <= '0;
			ready_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			hdl_q <= hdl_d;
			hdl_rsv_q <= hdl_rsv_d;
			svc_q <= svc_d;
			tok_q <= tok_d;
			pk_q <= pk_d;
			lat_q <= lat_d;
			dv_q <= dv_d;
			idx_q <= idx_d;
			lm_req_q <= lm_req_d;
			lm_op_q <= lm_op_d;
			ev_valid_q <= ev_valid_d;
			ev_code_q <= ev_code_d;
			ev_st_q <= ev_st_d;
			ev_role_q <= ev_role_d;
			ev_svc_q <= ev_svc_d;
			ev_tok_q <= ev_tok_d;
			ev_pk_q <= ev_pk_d;
			ev_lat_q <= ev_lat_d;
			ev_dv_q <= ev_dv_d;
			ready_q <= ready_d;
		end
	end

	assign cmd_ready = ready_q;
	assign lm_req = lm_req_q;
	assign lm_op = lm_op_q;
	assign lm_handle = hdl_q;
	assign lm_service_type = svc_q;
	assign lm_token_rate = tok_q;
	assign lm_peak_bw = pk_q;
	assign lm_latency_us = lat_q;
	assign lm_delay_var_us = dv_q;
	assign ev_valid = ev_valid_q;
	assign ev_code = ev_code_q;
	assign ev_opcode = op_q;
	assign ev_status = ev_st_q;
	assign ev_handle = hdl_q;
	assign ev_role = ev_role_q;
	assign ev_service_type = ev_svc_q;
	assign ev_token_rate = ev_tok_q;
	assign ev_peak_bw = ev_pk_q;
	assign ev_latency_us = ev_lat_q;
	assign ev_delay_var_us = ev_dv_q;

	// ==========================================================
	// checks
	// ==========================================================
	sequence s_accept;
		cmd_valid && cmd_ready;
	endsequence

	a_role_complete: assert property (@(posedge mclk) disable iff (!rst_b)
		s_accept and (command_field_code == CODE_ROLE_QUERY) && event_mask[EVM_COMPLETE]
		|-> ##4 ev_valid && ev_code == EV_CMD_COMPLETE)
		else $error("role query did not complete in four cycles");
	a_status_first: assert property (@(posedge mclk) disable iff (!rst_b)
		lm_req |-> ev_code == EV_CMD_STATUS)
		else $error("link manager started before status event");
	a_no_complete: assert property (@(posedge mclk) disable iff (!rst_b)
		ev_valid && ev_code == EV_CMD_COMPLETE |-> op_q == CODE_ROLE_QUERY)
		else $error("complete event for wrong command");
	a_mask_gate: assert property (@(posedge mclk) disable iff (!rst_b)
		ev_valid && ev_code == EV_CMD_STATUS |-> $past(event_mask[EVM_STATUS]))
		else $error("masked status event sent");
	a_role_code: assert property (@(posedge mclk) disable iff (!rst_b)
		ev_valid && ev_code == EV_CMD_COMPLETE |-> ev_role <= ROLE_SLAVE)
		else $error("bad role code");
	a_rsv_reject: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q == S_CHECK && hdl_rsv_q |=> !lm_req && ev_status != ST_SUCCESS)
		else $error("reserved handle accepted");
	a_svc_type: assert property (@(posedge mclk) disable iff (!rst_b)
		lm_req && lm_op != LM_OP_UNPARK |-> lm_service_type <= SVC_GUARANTEED)
		else $error("reserved service type passed on");
	a_qos_dir: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q == S_CHECK && op_q == CODE_SVC_QUALITY && rd_slave && lm_req_d
		|=> lm_op == LM_OP_QOS_TO_MASTER)
		else $error("slave request not sent to master");
endmodule // lpcd_decoder

/* File: rtl/lpcd_pkg.sv */
// Functional notes
// - leave-parked command 0x0006 unparks named link
// - handle 12 bits, 0x0f00-0x0fff reserved
// - status event first, later mode change
// - service request 0x0007, seven fields ordered
// - flags reserved; service types 0,1,2 valid
// - token rate, peak bandwidth four bytes
// - latency, delay variation four bytes microseconds
// - status event, then done event, no complete
// - peer may also raise done event
// - slave asks master; master asks slave
// - link manager decides parameters satisfiable
// - role query 0x0009 returns status, handle, role
// - status zero success, nonzero error code
// - role 0x00 master, 0x01 slave
// - returned handle equals queried handle
// - role query ends with complete event
// - events sent only when unmasked
package lpcd_pkg;
	localparam logic [9:0] CODE_LEAVE_PARK = 10'h006;
	localparam logic [9:0] CODE_SVC_QUALITY = 10'h007;
	localparam logic [9:0] CODE_ROLE_QUERY = 10'h009;
	localparam int HANDLE_W = 12;
	localparam logic [11:0] HANDLE_MAX = 12'heff;
	localparam logic [7:0] SVC_NO_TRAFFIC = 8'h00;
	localparam logic [7:0] SVC_BEST_EFFORT = 8'h01;
	localparam logic [7:0] SVC_GUARANTEED = 8'h02;
	localparam logic [7:0] ST_SUCCESS = 8'h00;
	localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
	localparam logic [7:0] ST_NO_CONN = 8'h02;
	localparam logic [7:0] ST_BAD_PARAM = 8'h12;
	localparam logic [7:0] ROLE_MASTER = 8'h00;
	localparam logic [7:0] ROLE_SLAVE = 8'h01;
	localparam int N_LINKS = 8;
	localparam int IDX_W = 3;
	// event-mask bit positions
	localparam int EVM_STATUS = 0;
	localparam int EVM_COMPLETE = 1;
	localparam int EVM_MODE = 2;
	localparam int EVM_QOS = 3;
	typedef enum logic [2:0] {
		EV_NONE = 3'b000,
		EV_CMD_STATUS = 3'b001,
		EV_CMD_COMPLETE = 3'b010,
		EV_MODE_CHANGE = 3'b011,
		EV_QOS_DONE = 3'b100
	} lpcd_ev_t;
	typedef enum logic [1:0] {
		LM_OP_UNPARK = 2'b00,
		LM_OP_QOS_TO_MASTER = 2'b01,
		LM_OP_QOS_TO_SLAVE = 2'b10
	} lpcd_lmop_t;
endpackage

/* File: rtl/lpcd_link_table.sv */
`timescale 1ns/1ps
// per-link state: active async link, parked, local role slave
module lpcd_link_table
	import lpcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic wr_active,
	input wire logic wr_parked,
	input wire logic wr_slave,
	input wire logic park_clr,
	input wire logic [IDX_W-1:0] park_idx,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic rd_active,
	output logic rd_parked,
	output logic rd_slave
);
	logic [N_LINKS-1:0] act_q, act_d, prk_q, prk_d, slv_q, slv_d;
	logic rd_a_q, rd_p_q, rd_s_q;

	genvar g;
	generate
		for (g = 0; g < N_LINKS; g++) begin : g_ent
			always_comb begin
				act_d[g] = act_q[g];
				prk_d[g] = prk_q[g];
				slv_d[g] = slv_q[g];
				if (park_clr && park_idx == IDX_W'(g)) begin
					prk_d[g] = 1'b0;
				end
				if (wr_en && wr_idx == IDX_W'(g)) begin
					act_d[g] = wr_active;
					prk_d[g] = wr_parked;
					slv_d[g] = wr_slave;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			act_q <= '0;
			prk_q <= '0;
			slv_q <= '0;
			rd_a_q <= 1'b0;
			rd_p_q <= 1'b0;
			rd_s_q <= 1'b0;
		end else begin
			act_q <= act_d;
			prk_q <= prk_d;
			slv_q <= slv_d;
			rd_a_q <= act_q[rd_idx];
			rd_p_q <= prk_q[rd_idx];
			rd_s_q <= slv_q[rd_idx];
		end
	end
	assign rd_active = rd_a_q;
	assign rd_parked = rd_p_q;
	assign rd_slave = rd_s_q;
endmodule // lpcd_link_table

/* File: rtl/lpcd_handle_map.sv */
`timescale 1ns/1ps
// associative map from 12-bit handle to link slot index
module lpcd_handle_map
	import lpcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic set_en,
	input wire logic [IDX_W-1:0] set_idx,
	input wire logic [HANDLE_W-1:0] set_handle,
	input wire logic [HANDLE_W-1:0] look_handle,
	output logic hit,
	output logic [IDX_W-1:0] hit_idx
);
	logic [HANDLE_W-1:0] hdl_q [N_LINKS];
	logic [N_LINKS-1:0] match;
	logic hit_q;
	logic [IDX_W-1:0] idx_q;
	logic [IDX_W-1:0] idx_d;

	genvar g;
	generate
		for (g = 0; g < N_LINKS; g++) begin : g_ent
			assign match[g] = (hdl_q[g] == look_handle);
			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					hdl_q[g] <= 12'hfff;
				end else if (set_en && set_idx == IDX_W'(g)) begin
					hdl_q[g] <= set_handle;
				end
			end
		end
	endgenerate

	always_comb begin
		idx_d = '0;
		for (int i = N_LINKS - 1; i >= 0; i--) begin
			if (match[i]) begin
				idx_d = IDX_W'(i);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			hit_q <= 1'b0;
			idx_q <= '0;
		end else begin
			hit_q <= |match;
			idx_q <= idx_d;
		end
	end
	assign hit = hit_q;
	assign hit_idx = idx_q;
endmodule // lpcd_handle_map

/* File: verif/lpcd_lm_model.sv */
`timescale 1ns/1ps
// ==========
// link manager stand-in: answers each request after reply_delay cycles
module lpcd_lm_model
	import lpcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic lm_req,
	input wire logic [7:0] lm_service_type,
	input wire logic [31:0] lm_token_rate,
	input wire logic [31:0] lm_peak_bw,
	input wire logic [31:0] lm_latency_us,
	input wire logic [31:0] lm_delay_var_us,
	input wire logic [7:0] reply_status,
	input wire logic [7:0] reply_delay,
	input wire logic remote_go,
	output logic lm_done,
	output logic lm_remote_qos,
	output logic [7:0] lm_status,
	output logic [7:0] lm_service_type_g,
	output logic [31:0] lm_token_rate_g,
	output logic [31:0] lm_peak_bw_g,
	output logic [31:0] lm_latency_g,
	output logic [31:0] lm_delay_var_g
);
	logic [7:0] cnt_q, st_q, sv_q;
	logic [31:0] tr_q, pk_q, lat_q, dv_q;
	logic show;
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_q <= 8'h00;
			st_q <= 8'h00;
			lm_done <= 1'b0;
			lm_remote_qos <= 1'b0;
		end else begin
			lm_done <= (cnt_q == 8'h01);
			lm_remote_qos <= remote_go;
			cnt_q <= (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
			if (lm_req) begin
				cnt_q <= reply_delay;
				st_q <= reply_status;
				sv_q <= lm_service_type;
				tr_q <= lm_token_rate >> 1;
				pk_q <= lm_peak_bw;
				lat_q <= lm_latency_us + 32'h1;
				dv_q <= lm_delay_var_us;
			end
		end
	end
	// answer fields hold meaning only in a done or remote-qos cycle; elsewhere show the inverse
	assign show = lm_done | lm_remote_qos;
	assign lm_status = show ? st_q : ~st_q;
	assign lm_service_type_g = show ? sv_q : ~sv_q;
	assign lm_token_rate_g = show ? tr_q : ~tr_q;
	assign lm_peak_bw_g = show ? pk_q : ~pk_q;
	assign lm_latency_g = show ? lat_q : ~lat_q;
	assign lm_delay_var_g = show ? dv_q : ~dv_q;
endmodule // lpcd_lm_model

/* File: verif/link_policy_command_decoder_tb_top.sv */
`timescale 1ns/1ps
module link_policy_command_decoder_tb_top
	import lpcd_pkg::*;
;
	localparam logic [11:0] H_M = 12'h001;
	localparam logic [11:0] H_S = 12'heff;
	localparam logic [31:0] PK = 32'h0001_f400;
	localparam logic [31:0] LAT = 32'h0000_2710;
	localparam logic [31:0] DV = 32'h0000_03e8;
	logic mclk, rst_b, cmd_valid, cmd_ready, link_set, l_par, l_slv, l_act, remote_go;
	logic lm_req, lm_done, lm_remote_qos, ev_valid;
	logic [9:0] command_field_code, ev_opcode;
	logic [15:0] cmd_handle;
	logic [7:0] cmd_service_type, reply_status, reply_delay, lm_status, lm_st, lm_sv_g;
	logic [7:0] ev_status, ev_role, ev_service_type;
	logic [31:0] cmd_token_rate, lm_tr, lm_pk, lm_lat, lm_dv, lm_tr_g, lm_pk_g, lm_lat_g, lm_dv_g;
	logic [31:0] ev_token_rate, ev_peak_bw, ev_latency_us, ev_delay_var_us;
	logic [3:0] event_mask;
	logic [2:0] l_idx, ev_code;
	logic [1:0] lm_op;
	logic [11:0] l_h, lm_handle, ev_handle;
	int n_fail, checks;
	always #2.5 mclk = ~mclk;
	lpcd_decoder uut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.command_field_code(command_field_code), .cmd_handle(cmd_handle), .cmd_flags(8'hff),
		.cmd_service_type(cmd_service_type), .cmd_token_rate(cmd_token_rate), .cmd_peak_bw(PK),
		.cmd_latency_us(LAT), .cmd_delay_var_us(DV), .cmd_ready(cmd_ready),
		.event_mask(event_mask), .link_set(link_set), .link_set_idx(l_idx),
		.link_set_handle(l_h), .link_set_active(l_act), .link_set_parked(l_par),
		.link_set_slave(l_slv), .lm_req(lm_req), .lm_op(lm_op), .lm_handle(lm_handle),
		.lm_service_type(lm_st), .lm_token_rate(lm_tr), .lm_peak_bw(lm_pk),
		.lm_latency_us(lm_lat), .lm_delay_var_us(lm_dv), .lm_done(lm_done),
		.lm_status(lm_status), .lm_service_type_g(lm_sv_g), .lm_token_rate_g(lm_tr_g),
		.lm_peak_bw_g(lm_pk_g), .lm_latency_g(lm_lat_g), .lm_delay_var_g(lm_dv_g),
		.lm_remote_qos(lm_remote_qos), .ev_valid(ev_valid), .ev_code(ev_code),
		.ev_opcode(ev_opcode), .ev_status(ev_status), .ev_handle(ev_handle), .ev_role(ev_role),
		.ev_service_type(ev_service_type), .ev_token_rate(ev_token_rate),
		.ev_peak_bw(ev_peak_bw), .ev_latency_us(ev_latency_us),
		.ev_delay_var_us(ev_delay_var_us));
	lpcd_lm_model lm (.mclk(mclk), .rst_b(rst_b), .lm_req(lm_req), .lm_service_type(lm_st),
		.lm_token_rate(lm_tr), .lm_peak_bw(lm_pk), .lm_latency_us(lm_lat),
		.lm_delay_var_us(lm_dv), .reply_status(reply_status), .reply_delay(reply_delay),
		.remote_go(remote_go), .lm_done(lm_done), .lm_remote_qos(lm_remote_qos),
		.lm_status(lm_status), .lm_service_type_g(lm_sv_g), .lm_token_rate_g(lm_tr_g),
		.lm_peak_bw_g(lm_pk_g), .lm_latency_g(lm_lat_g), .lm_delay_var_g(lm_dv_g));
	// ==========
	// helpers
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic link_wr(input logic [2:0] i, input logic [11:0] h, input logic p,
		input logic s, input logic a);
		@(posedge mclk);
		link_set <= 1'b1;
		l_act <= a;
		l_idx <= i;
		l_h <= h;
		l_par <= p;
		l_slv <= s;
		@(posedge mclk);
		link_set <= 1'b0;
	endtask
	task automatic send(input logic [9:0] op, input logic [15:0] h, input logic [7:0] st);
		int i;
		@(posedge mclk);
		command_field_code <= op;
		cmd_handle <= h;
		cmd_service_type <= st;
		cmd_valid <= 1'b1;
		i = 0;
		do begin
			@(negedge mclk);
			i++;
		end while (cmd_ready !== 1'b1 && i < 80);
		chk(i < 80, "command never taken");
		if (i >= 80) stop_test();
		@(posedge mclk);
		cmd_valid <= 1'b0;
	endtask
	task automatic wait_ev(input logic [2:0] code, input string m);
		int i;
		i = 0;
		do begin
			@(negedge mclk);
			i++;
		end while (ev_valid !== 1'b1 && i < 80);
		chk(ev_valid === 1'b1 && ev_code === code, m);
		if (i >= 80) stop_test();
	endtask
	task automatic no_ev(input int n);
		repeat (n) begin
			@(negedge mclk);
			chk(ev_valid === 1'b0 && lm_req === 1'b0, "unexpected event or request");
		end
	endtask
	// ==========
	// scenarios
	task automatic t_role();
		send(CODE_ROLE_QUERY, 16'hf001, 8'h00);
		wait_ev(EV_CMD_COMPLETE, "role query event");
		chk(ev_status === ST_SUCCESS && ev_opcode === CODE_ROLE_QUERY, "role status");
		chk(ev_handle === H_M && ev_role === ROLE_MASTER, "master role");
		send(CODE_ROLE_QUERY, {4'h0, H_S}, 8'h00);
		wait_ev(EV_CMD_COMPLETE, "role query event");
		chk(ev_handle === H_S && ev_role === ROLE_SLAVE, "slave role");
		send(CODE_ROLE_QUERY, 16'h0f00, 8'h00);
		wait_ev(EV_CMD_COMPLETE, "reserved handle event");
		chk(ev_status === ST_NO_CONN, "reserved handle status");
	endtask
	task automatic t_unpark();
		reply_delay <= 8'd40;
		send(CODE_LEAVE_PARK, {4'h0, H_S}, 8'h00);
		wait_ev(EV_CMD_STATUS, "unpark status first");
		chk(ev_status === ST_SUCCESS && ev_opcode === CODE_LEAVE_PARK, "unpark accepted");
		chk(lm_req === 1'b1 && lm_op === LM_OP_UNPARK && lm_handle === H_S, "unpark req");
		wait_ev(EV_MODE_CHANGE, "mode change after unpark");
		chk(ev_status === ST_SUCCESS && ev_handle === H_S, "mode change fields");
		send(CODE_LEAVE_PARK, {4'h0, H_S}, 8'h00);
		wait_ev(EV_CMD_STATUS, "second unpark status");
		chk(ev_status === ST_BAD_PARAM && lm_req === 1'b0, "unpark of active link");
		no_ev(12);
	endtask
	task automatic t_qos();
		int i;
		logic [11:0] h;
		reply_delay <= 8'd1;
		for (i = 0; i < 3; i++) begin
			h = i[0] ? H_S : H_M;
			reply_status <= 8'(i);
			cmd_token_rate <= 32'h100 << i;
			send(CODE_SVC_QUALITY, {4'h0, h}, 8'(i));
			wait_ev(EV_CMD_STATUS, "service status first");
			chk(lm_op === (i[0] ? LM_OP_QOS_TO_MASTER : LM_OP_QOS_TO_SLAVE), "lm op");
			chk(lm_st === 8'(i) && lm_tr === (32'h100 << i) && lm_pk === PK, "lm rates");
			chk(lm_lat === LAT && lm_dv === DV && lm_handle === h, "lm times");
			wait_ev(EV_QOS_DONE, "service done event");
			chk(ev_status === 8'(i) && ev_service_type === 8'(i), "done status");
			chk(ev_token_rate === (32'h80 << i) && ev_peak_bw === PK, "granted rates");
			chk(ev_latency_us === LAT + 32'h1 && ev_delay_var_us === DV, "granted times");
			no_ev(3);
		end
		@(posedge mclk);
		remote_go <= 1'b1;
		@(posedge mclk);
		remote_go <= 1'b0;
		wait_ev(EV_QOS_DONE, "peer side done event");
		chk(ev_status === 8'h02 && ev_token_rate === 32'h200, "peer side values");
		send(CODE_SVC_QUALITY, {4'h0, H_M}, 8'h03);
		wait_ev(EV_CMD_STATUS, "reserved service type");
		chk(ev_status === ST_BAD_PARAM && lm_req === 1'b0, "reserved service type");
		no_ev(8);
	endtask
	task automatic t_misc();
		send(10'h008, {4'h0, H_M}, 8'h00);
		wait_ev(EV_CMD_STATUS, "unknown opcode event");
		chk(ev_status === ST_UNKNOWN_CMD, "unknown opcode status");
		link_wr(3'd2, 12'h0a0, 1'b0, 1'b0, 1'b0);
		send(CODE_ROLE_QUERY, 16'h00a0, 8'h00);
		wait_ev(EV_CMD_COMPLETE, "inactive link event");
		chk(ev_status === ST_NO_CONN, "inactive link status");
		@(posedge mclk);
		event_mask <= 4'b1101;
		send(CODE_ROLE_QUERY, {4'h0, H_M}, 8'h00);
		no_ev(10);
		chk(cmd_ready === 1'b1, "ready after masked query");
		event_mask <= 4'b1111;
	endtask
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		command_field_code = 10'h000;
		cmd_handle = 16'h0000;
		cmd_service_type = 8'h00;
		cmd_token_rate = 32'h0;
		event_mask = 4'b1111;
		link_set = 1'b0;
		l_idx = 3'd0;
		l_h = 12'h000;
		l_par = 1'b0;
		l_slv = 1'b0;
		l_act = 1'b1;
		reply_status = 8'h00;
		reply_delay = 8'd1;
		remote_go = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		link_wr(3'd0, H_M, 1'b0, 1'b0, 1'b1);
		link_wr(3'd1, H_S, 1'b1, 1'b1, 1'b1);
		t_role();
		t_unpark();
		t_qos();
		t_misc();
		stop_test();
	end
endmodule // link_policy_command_decoder_tb_top
